// ==== logic/osc_trim_pkg.sv ====
`default_nettype none
package osc_trim_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_OSC_FINE_TRIM   = 8'h9E;
  localparam logic [7:0] ADDR_OSC_CONTROL     = 8'hA1;
  localparam logic [7:0] ADDR_OSC_COARSE_TRIM = 8'hA2;
  localparam logic [7:0] REG_PAGE             = 8'h0F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EN_HI      = 7;
  localparam int EN_LO      = 6;
  localparam int SUSPEND_B  = 5;
  localparam int READY_B    = 4;
  localparam int RSVD_B     = 3;
  localparam int DIV_HI     = 2;
  localparam int COARSE_HI  = 6;
  localparam int FINE_HI    = 5;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] EN_STOP         = 2'h0;
  localparam logic [1:0] EN_RUN          = 2'h3;
  localparam logic [1:0] EN_RESET        = 2'h3;
  localparam logic [2:0] DIV_RESET       = 3'h0;
  localparam logic [6:0] COARSE_DEFAULT  = 7'h40;
  localparam logic [5:0] FINE_DEFAULT    = 6'h20;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ         = 250;
  localparam int SETTLE_NS       = 40;
  localparam int SETTLE_CYCLES   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W        = 4;

  typedef struct packed {
    logic [1:0] enable;
    logic       suspend;
    logic [2:0] divider;
  } osc_ctrl_t;

  typedef struct packed {
    logic [6:0] coarse;
    logic [5:0] fine;
  } osc_trim_t;

endpackage
`default_nettype wire

// ==== logic/osc_core_divider.sv ====
`default_nettype none
module osc_core_divider
  import osc_trim_pkg::*;
(
  input  wire logic       clk,       // Oscillator-rate clock.
  input  wire logic       rst_b,     // Synchronous reset, active low.
  input  wire logic       run,       // Oscillator running.
  input  wire logic [2:0] div_code,  // Post-divider code.
  output logic            tick       // One pulse per divided period.
);

  logic [6:0] count;

  function automatic logic [6:0] div_limit(input logic [2:0] code);
    div_limit = 7'((8'h80 >> code) - 8'h01);
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (count >= div_limit(div_code)) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== logic/internal_osc_control_trim.sv ====
`default_nettype none
module internal_osc_control_trim
  import osc_trim_pkg::*;
#(
  parameter logic [6:0] CAL_COARSE = COARSE_DEFAULT,  // Factory coarse trim.
  parameter logic [5:0] CAL_FINE   = FINE_DEFAULT     // Factory fine trim.
) (
  input  wire logic       clk,          // 250 MHz clock.
  input  wire logic       rst_b,        // Synchronous reset, active low.
  input  wire logic [7:0] reg_addr,     // Register address.
  input  wire logic [7:0] reg_page,     // Register page.
  input  wire logic       reg_wr,       // Write strobe.
  input  wire logic       reg_rd,       // Read strobe.
  input  wire logic [7:0] reg_wdata,    // Write data.
  input  wire logic [3:0] port_match,   // Port 0..3 match events, async.
  input  wire logic       cmp0_enable,  // Comparator 0 enabled, async.
  input  wire logic       cmp0_out,     // Comparator 0 output, async.
  output logic [7:0]      reg_rdata,    // Read data.
  output logic            osc_run,      // Oscillator running.
  output logic            core_clock_en,// Core clock gate enable.
  output logic            core_tick,    // Divided core clock pulse.
  output logic [6:0]      trim_coarse,  // Coarse period trim to the analog cell.
  output logic [5:0]      trim_fine     // Fine period trim to the analog cell.
);

  // ****************************************
  // Registers
  // ****************************************
  osc_ctrl_t          ctrl;
  osc_trim_t          trim;
  logic               ready;
  logic [SETTLE_W-1:0] settle;
  logic [5:0]         wake_meta;
  logic [5:0]         wake_sync;
  logic               wake;
  logic               sel_page;
  logic               next_run;
  logic               div_tick;
  logic               wr_ctrl;
  logic               wr_coarse;
  logic               wr_fine;

  // ****************************************
  // Register decode
  // ****************************************
  // True when a strobe on the register page names the given register.
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [7:0] page,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_hit = strobe && (page == REG_PAGE) && (addr == target);
  endfunction

  assign sel_page  = (reg_page == REG_PAGE);
  assign wr_ctrl   = reg_hit(reg_wr, reg_page, reg_addr, ADDR_OSC_CONTROL);
  assign wr_coarse = reg_hit(reg_wr, reg_page, reg_addr, ADDR_OSC_COARSE_TRIM);
  assign wr_fine   = reg_hit(reg_wr, reg_page, reg_addr, ADDR_OSC_FINE_TRIM);

  // ****************************************
  // Wake-up events
  // ****************************************
  // The wake inputs come from other clock domains, so only the second stage is read.
  // synchronised wake
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_meta <= 6'h00;
      wake_sync <= 6'h00;
    end else begin
      wake_meta <= {cmp0_enable, cmp0_out, port_match};
      wake_sync <= wake_meta;
    end
  end

  // Comparator 0 wakes only while it is enabled and its output is low.
  // wake decode
  assign wake = (|wake_sync[3:0]) || (wake_sync[5] && !wake_sync[4]);

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl.enable  <= EN_RESET;
      ctrl.suspend <= 1'b0;
      ctrl.divider <= DIV_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl.enable  <= reg_wdata[EN_HI:EN_LO];
        ctrl.divider <= reg_wdata[DIV_HI:0];
      end
      // A suspend write wins over a wake in the same cycle, so the request is never lost.
      // Writing 0 leaves the bit alone; only a wake-up event clears it.
      // suspend set, wake clears
      if (wr_ctrl && reg_wdata[SUSPEND_B]) begin
        ctrl.suspend <= 1'b1;
      end else if (wake) begin
        ctrl.suspend <= 1'b0;
      end
    end
  end

  // ****************************************
  // Trim registers
  // ****************************************
  // calibrated reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trim.coarse <= CAL_COARSE;
      trim.fine   <= CAL_FINE;
    end else begin
      if (wr_coarse) begin
        trim.coarse <= reg_wdata[COARSE_HI:0];
      end
      if (wr_fine) begin
        trim.fine <= reg_wdata[FINE_HI:0];
      end
    end
  end

  // ****************************************
  // Oscillator state
  // ****************************************
  // enable decode
  always_comb begin
    next_run = (ctrl.enable == EN_RUN) && !ctrl.suspend;
  end

  // The counter starts full: out of reset the oscillator already runs calibrated.
  // ready after settle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      settle <= SETTLE_W'(SETTLE_CYCLES);
      ready  <= 1'b0;
    end else if (!next_run) begin
      settle <= '0;
      ready  <= 1'b0;
    end else if (settle < SETTLE_W'(SETTLE_CYCLES)) begin
      settle <= settle + SETTLE_W'(1);
      ready  <= 1'b0;
    end else begin
      ready  <= 1'b1;
    end
  end

  // ****************************************
  // Post-divider
  // ****************************************
  osc_core_divider osc_core_divider_inst (
    .clk      (clk),
    .rst_b    (rst_b),
    .run      (next_run),
    .div_code (ctrl.divider),
    .tick     (div_tick)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // The core clock gate follows the oscillator; a stopped oscillator stops the core.
  // core clock gate
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_run       <= 1'h0;
      core_clock_en <= 1'h0;
    end else begin
      osc_run       <= next_run;
      core_clock_en <= next_run;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      core_tick <= 1'h0;
    end else begin
      core_tick <= div_tick;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trim_coarse <= CAL_COARSE;
      trim_fine   <= CAL_FINE;
    end else begin
      trim_coarse <= trim.coarse;
      trim_fine   <= trim.fine;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && sel_page) begin
      case (reg_addr)
        ADDR_OSC_CONTROL:
          reg_rdata <= {ctrl.enable, ctrl.suspend, ready, 1'b0, ctrl.divider};
        ADDR_OSC_COARSE_TRIM:
          reg_rdata <= {1'b0, trim.coarse};
        ADDR_OSC_FINE_TRIM:
          reg_rdata <= {2'h0, trim.fine};
        default:
          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ==== verif/osc_trim_checker.sv ====
`default_nettype none
module osc_trim_checker
  import osc_trim_pkg::*;
(
  input wire logic       clk,           // Clock.
  input wire logic       rst_b,         // Reset.
  input wire logic [7:0] reg_addr,      // Address.
  input wire logic [7:0] reg_page,      // Page.
  input wire logic       reg_wr,        // Write.
  input wire logic       reg_rd,        // Read.
  input wire logic [7:0] reg_wdata,     // Write data.
  input wire logic [7:0] reg_rdata,     // Read data.
  input wire logic       osc_run,       // Running.
  input wire logic       core_clock_en, // Gate.
  input wire logic [6:0] trim_coarse    // Coarse trim.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic       sel  = reg_page == REG_PAGE;
  wire logic       wr_c = reg_wr && sel && reg_addr == ADDR_OSC_CONTROL;
  wire logic       rd_c = reg_rd && sel && reg_addr == ADDR_OSC_CONTROL;
  wire logic       crs  = sel && reg_addr == ADDR_OSC_COARSE_TRIM;
  wire logic       fin  = sel && reg_addr == ADDR_OSC_FINE_TRIM;
  wire logic [6:0] wd_c = reg_wdata[6:0];
  sequence s_halt;
    ##[1:3] !osc_run;
  endsequence
  sequence s_gate_off;
    ##[1:3] !core_clock_en;
  endsequence
  property p_stop; wr_c && reg_wdata[7:6] == EN_STOP |-> s_halt; endproperty
  a_stop: assert property (p_stop) else $error("enable 00 did not stop");
  property p_susp; wr_c && reg_wdata[SUSPEND_B] |-> s_halt; endproperty
  a_susp: assert property (p_susp) else $error("suspend did not halt");
  property p_rdy; rd_c && !osc_run && !$past(osc_run) |=> !reg_rdata[READY_B]; endproperty
  a_rdy: assert property (p_rdy) else $error("ready while stopped");
  property p_rsvd; rd_c |=> !reg_rdata[RSVD_B]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_crs_w; reg_wr && crs |-> ##2 trim_coarse == $past(wd_c, 2); endproperty
  a_crs_w: assert property (p_crs_w) else $error("coarse trim not written");
  property p_crs7; reg_rd && crs |=> !reg_rdata[7]; endproperty
  a_crs7: assert property (p_crs7) else $error("coarse top bit set");
  property p_fine; reg_rd && fin |=> reg_rdata[7:6] == 2'h0; endproperty
  a_fine: assert property (p_fine) else $error("fine upper bits set");
  property p_gate; core_clock_en == osc_run; endproperty
  a_gate: assert property (p_gate) else $error("core gate mismatch");
  property p_gate_off; wr_c && reg_wdata[SUSPEND_B] |-> s_gate_off; endproperty
  a_gate_off: assert property (p_gate_off) else $error("suspend left core gate on");
endmodule
bind internal_osc_control_trim osc_trim_checker osc_trim_checker_inst (.clk, .rst_b,
  .reg_addr, .reg_page, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .osc_run,
  .core_clock_en, .trim_coarse);
`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none
module tb import osc_trim_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] CAL_C = 7'h2B;
  localparam logic [5:0] CAL_F = 6'h15;
  logic        clk, rst_b, reg_wr, reg_rd, cmp0_enable, cmp0_out;
  logic        osc_run, core_clock_en, core_tick;
  logic [7:0]  reg_addr, reg_page, reg_wdata, reg_rdata;
  logic [3:0]  port_match;
  logic [6:0]  trim_coarse;
  logic [5:0]  trim_fine;
  int          errors, comparisons, cyc, n;
  logic [23:0] rows [6] = '{24'hA2FF7F, 24'hA20000, 24'h9EFF3F, 24'h9E0000,
                            24'hA1C5D5, 24'h55FF00};
  internal_osc_control_trim #(.CAL_COARSE(CAL_C), .CAL_FINE(CAL_F))
    internal_osc_control_trim_inst (.clk, .rst_b, .reg_addr, .reg_page, .reg_wr,
    .reg_rd, .reg_wdata, .port_match, .cmp0_enable, .cmp0_out, .reg_rdata,
    .osc_run, .core_clock_en, .core_tick, .trim_coarse, .trim_fine);
  task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string s);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(s, reg_rdata, exp);
  endtask
  task automatic run_is(logic e);
    repeat (6) @(posedge clk);
    #1 chk("osc_run", {7'h00, osc_run}, {7'h00, e});
    chk("core_clock_en", {7'h00, core_clock_en}, {7'h00, e});
  endtask
  task print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    {rst_b, reg_wr, reg_rd, cmp0_enable, port_match} = '0;
    {reg_addr, reg_wdata, cmp0_out} = '0;
    reg_page = REG_PAGE;
    cmp0_out = 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("trim out", {1'b0, trim_coarse}, {1'b0, CAL_C});
    chk("trim fine reset", {2'h0, trim_fine}, {2'h0, CAL_F});
    rd(ADDR_OSC_COARSE_TRIM, {1'b0, CAL_C}, "coarse");
    rd(ADDR_OSC_FINE_TRIM, {2'h0, CAL_F}, "fine");
    rd(ADDR_OSC_CONTROL, 8'hD0, "control");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0], "row");
    end
    reg_page <= 8'h00;
    wr(ADDR_OSC_COARSE_TRIM, 8'h11);
    reg_page <= REG_PAGE;
    rd(ADDR_OSC_COARSE_TRIM, 8'h00, "off page");
    wr(ADDR_OSC_COARSE_TRIM, 8'hDA);
    wr(ADDR_OSC_FINE_TRIM, 8'hE7);
    repeat (2) @(posedge clk);
    #1 chk("trim coarse out", {1'b0, trim_coarse}, 8'h5A);
    chk("trim fine out", {2'h0, trim_fine}, 8'h27);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_OSC_CONTROL, 8'hC0 | 8'(c));
      for (int k = 0; k < 3; k++) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (!core_tick && n < 300);
      end
      chk("tick gap", 8'(n), 8'(128 >> c));
    end
    wr(ADDR_OSC_CONTROL, 8'h00);
    run_is(1'b0);
    rd(ADDR_OSC_CONTROL, 8'h00, "stopped");
    wr(ADDR_OSC_CONTROL, 8'hC0);
    rd(ADDR_OSC_CONTROL, 8'hC0, "settling");
    repeat (14) @(posedge clk);
    rd(ADDR_OSC_CONTROL, 8'hD0, "restart");
    wr(ADDR_OSC_CONTROL, 8'hE0);
    cmp0_enable <= 1'b1;
    run_is(1'b0);
    rd(ADDR_OSC_CONTROL, 8'hE0, "suspended");
    port_match <= 4'h8;
    run_is(1'b1);
    port_match <= 4'h0;
    wr(ADDR_OSC_CONTROL, 8'hE0);
    run_is(1'b0);
    cmp0_out <= 1'b0;
    run_is(1'b1);
    chk("gate", {7'h00, core_clock_en}, 8'h01);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_OSC_CONTROL, 8'hD0, "control after reset");
    rd(ADDR_OSC_COARSE_TRIM, {1'b0, CAL_C}, "coarse after reset");
    rd(ADDR_OSC_FINE_TRIM, {2'h0, CAL_F}, "fine after reset");
    print_verdict;
  end
endmodule
`default_nettype wire
